/* verilog/tbo_cfg.svh */
// register offsets, field positions and reset values of the break/output and burst block
`ifndef TBO_CFG_SVH
`define TBO_CFG_SVH
`define TBO_OFF_BOC 8'h44
`define TBO_OFF_DBC 8'h48
`define TBO_OFF_WIN 8'h4c
`define TBO_OFF_BCFG 8'h50
`define TBO_OFF_STAT 8'h54
`define TBO_OFF_MASK 8'h58
`define TBO_CTRL1_ADDR 8'h00
`define TBO_BOC_RST 16'h0000
`define TBO_DBC_RST 16'h0000
`define TBO_LOCK_LSB 8
`define TBO_IDLE_BIT 10
`define TBO_RUN_BIT 11
`define TBO_BREAK_ENABLE_BIT 12
`define TBO_BREAK_POLARITY_BIT 13
`define TBO_AOE_BIT 14
`define TBO_MOE_BIT 15
`define TBO_BASE_LSB 0
`define TBO_LEN_LSB 8
`define TBO_ST_BREAK 0
`define TBO_ST_AUTO 1
`define TBO_ST_WRAP 2
`endif

/* verilog/tbo_pkg.sv */
// types shared by the break/output and burst block
package tbo_pkg;
  typedef enum logic [1:0] {
    TBO_ST_IDLE = 2'b00,
    TBO_ST_HI = 2'b01,
    TBO_ST_LO = 2'b10,
    TBO_ST_RESP = 2'b11
  } tbo_bus_st_t;
endpackage

/* verilog/tbo_sync.sv */
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module tbo_sync #(
  parameter int W = 1
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous level
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // tbo_sync

/* verilog/tbo_out_stage.sv */
// per-channel output stage: off-state handling, dead time, polarity
`timescale 1ns/1ns
module tbo_out_stage #(
  parameter int NCH = 4
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic moe, // main output enable
  input wire logic idle_off, // idle off-state select
  input wire logic run_off, // run off-state select
  input wire logic [7:0] dead_time, // dead time in clock cycles
  input wire logic [NCH-1:0] oc_ref, // reference waveforms
  input wire logic [NCH-1:0] ch_en, // channel output enables
  input wire logic [NCH-1:0] comp_en, // complementary output enables
  input wire logic [NCH-1:0] ch_pol, // channel output polarity
  input wire logic [NCH-1:0] comp_pol, // complementary polarity
  input wire logic [NCH-1:0] idle_lvl, // channel idle level
  input wire logic [NCH-1:0] idle_lvl_comp, // complementary idle level
  output logic [NCH-1:0] out_val, // channel output level
  output logic [NCH-1:0] out_en, // channel output driven
  output logic [NCH-1:0] outc_val, // complementary output level
  output logic [NCH-1:0] outc_en // complementary output driven
);
  logic moe_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) moe_d_r <= 1'b0;
    else moe_d_r <= moe;
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [7:0] cnt_r;
    logic ref_d_r;
    logic any_d_r;
    logic busy;
    assign busy = (cnt_r != 8'h00);

    // dead time restarts on every reference edge, mode change or rise of either enable while neither was set
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= 8'h00;
        ref_d_r <= 1'b0;
        any_d_r <= 1'b0;
      end else begin
        ref_d_r <= oc_ref[i];
        any_d_r <= ch_en[i] | comp_en[i];
        if ((oc_ref[i] != ref_d_r) || (moe != moe_d_r) || ((ch_en[i] | comp_en[i]) && !any_d_r))
          cnt_r <= dead_time;
        else if (busy)
          cnt_r <= cnt_r - 8'h01;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_val[i] <= 1'b0;
        out_en[i] <= 1'b0;
        outc_val[i] <= 1'b0;
        outc_en[i] <= 1'b0;
      end else if (moe) begin
        out_en[i] <= ch_en[i] | run_off;
        outc_en[i] <= comp_en[i] | run_off;
        out_val[i] <= ch_en[i] ? ((oc_ref[i] & !busy) ^ ch_pol[i]) : ch_pol[i];
        outc_val[i] <= comp_en[i] ? ((!oc_ref[i] & !busy) ^ comp_pol[i]) : comp_pol[i];
      end else begin
        out_en[i] <= idle_off & (ch_en[i] | comp_en[i]);
        outc_en[i] <= idle_off & (ch_en[i] | comp_en[i]);
        out_val[i] <= busy ? ch_pol[i] : idle_lvl[i];
        outc_val[i] <= busy ? comp_pol[i] : idle_lvl_comp[i];
      end
    end
  end
endmodule // tbo_out_stage

/* verilog/tbo_top.sv */
// break/output control and burst-window register block with APB slave
// What this block does
// - idle mode, off-state 0 keeps outputs disabled
// - idle off-state 1: inactive, then idle level
// - run mode off-state picks disabled or inactive
// - break acts only when enabled; polarity selects level
// - new break polarity acts one cycle later
// - active break clears main enable asynchronously
// - auto enable re-sets main enable on update
// - main enable gates channel and complementary outputs
// - lock level blocks break and auto bits
// - base field picks first burst target register
// - length field gives transfers as code plus one
// - each window access starts the next transfer
// - target is base plus offset plus index
// - byte mode splits item upper then lower
// - byte address uses four times the sum
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`include "tbo_cfg.svh"
module tbo_top import tbo_pkg::*; #(
  parameter int NCH = 4
) (
  input wire logic pclk, // bus clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic break_input, // break pin, asynchronous
  input wire logic upd_evt, // update event pulse from counter logic
  input wire logic [NCH-1:0] oc_ref, // reference waveforms
  input wire logic [NCH-1:0] channel_output_enable, // channel enables
  input wire logic [NCH-1:0] channel_comp_output_enable, // complementary enables
  input wire logic [NCH-1:0] ch_pol, // channel polarity
  input wire logic [NCH-1:0] comp_pol, // complementary polarity
  input wire logic [NCH-1:0] idle_lvl, // channel idle levels
  input wire logic [NCH-1:0] idle_lvl_comp, // complementary idle levels
  output logic [NCH-1:0] compare_output, // channel output levels
  output logic [NCH-1:0] compare_output_en, // channel outputs driven
  output logic [NCH-1:0] compare_output_comp, // complementary levels
  output logic [NCH-1:0] compare_output_comp_en, // complementary driven
  output logic main_output_enable, // main output enable state
  output logic burst_req, // one-cycle access to a timer register
  output logic burst_we, // burst access is a write
  output logic [7:0] burst_addr, // byte address of burst target
  output logic [15:0] burst_wdata, // burst write data
  input wire logic [15:0] burst_rdata, // target read data, same cycle as burst_req
  output logic irq // level interrupt
);
  if (NCH < 1 || NCH > 16) begin : g_chk
    $error("tbo_top: NCH must be 1..16");
  end

  tbo_bus_st_t state_r, state_nxt;
  logic [7:0] dt_r;
  logic [1:0] lock_r;
  logic idle_off_r, run_off_r, brk_en_r, brk_pol_r, brk_pol_eff_r, aoe_r, moe_r;
  logic [4:0] base_r, len_r, idx_r;
  logic byte_mode_r;
  logic [2:0] status_r, mask_r;
  logic brk_pin_s, brk_act_s, brk_act_d_r, moe_rst_n;
  logic setup, done, is_win, mapped, wr, two_left, wrap;
  logic [31:0] rd_val;
  logic [5:0] sum_hi, sum_lo, idx_step;
  logic brk_evt, auto_set, sw_moe_wr;

  assign setup = psel && !penable && (state_r == TBO_ST_IDLE);
  assign done = psel && penable && (state_r == TBO_ST_RESP);
  assign wr = done && pwrite;
  assign is_win = (paddr == `TBO_OFF_WIN);
  assign two_left = (idx_r < len_r);

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `TBO_OFF_BOC: rd_val = {16'h0000, moe_r, aoe_r, brk_pol_r, brk_en_r,
                              run_off_r, idle_off_r, lock_r, dt_r};
      `TBO_OFF_DBC: rd_val = {16'h0000, 3'h0, len_r, 3'h0, base_r};
      `TBO_OFF_BCFG: rd_val = {31'h0000_0000, byte_mode_r};
      `TBO_OFF_STAT: rd_val = {29'h0000_0000, status_r};
      `TBO_OFF_MASK: rd_val = {29'h0000_0000, mask_r};
      `TBO_OFF_WIN: rd_val = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  // bus sequencer: window accesses get one strobe per register touched
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TBO_ST_IDLE: if (psel && !penable) state_nxt = is_win ? TBO_ST_HI : TBO_ST_RESP;
      TBO_ST_HI: state_nxt = (byte_mode_r && two_left) ? TBO_ST_LO : TBO_ST_RESP;
      TBO_ST_LO: state_nxt = TBO_ST_RESP;
      TBO_ST_RESP: if (psel && penable) state_nxt = TBO_ST_IDLE;
      default: state_nxt = TBO_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TBO_ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pready <= (state_nxt == TBO_ST_RESP);
      if (setup) pslverr <= !mapped;
      else if (done) pslverr <= 1'b0;
    end
  end

  assign sum_hi = {1'b0, base_r} + {1'b0, idx_r};
  assign sum_lo = sum_hi + 6'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_req <= 1'b0;
      burst_we <= 1'b0;
      burst_addr <= 8'h00;
      burst_wdata <= 16'h0000;
    end else begin
      burst_req <= (state_nxt == TBO_ST_HI) || (state_nxt == TBO_ST_LO);
      if (state_nxt == TBO_ST_HI) begin
        burst_we <= pwrite;
        burst_addr <= `TBO_CTRL1_ADDR + {sum_hi, 2'b00};
        burst_wdata <= byte_mode_r ? {8'h00, pwdata[15:8]} : pwdata[15:0];
      end else if (state_nxt == TBO_ST_LO) begin
        burst_addr <= `TBO_CTRL1_ADDR + {sum_lo, 2'b00};
        burst_wdata <= {8'h00, pwdata[7:0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (setup) prdata <= rd_val;
    else if (state_r == TBO_ST_HI)
      prdata <= byte_mode_r ? {16'h0000, burst_rdata[7:0], 8'h00} : {16'h0000, burst_rdata};
    else if (state_r == TBO_ST_LO)
      prdata[7:0] <= burst_rdata[7:0];
  end

  assign idx_step = (byte_mode_r && two_left) ? 6'h02 : 6'h01;
  assign wrap = ({1'b0, idx_r} + idx_step) > {1'b0, len_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= 5'(`TBO_DBC_RST >> `TBO_BASE_LSB);
      len_r <= 5'(`TBO_DBC_RST >> `TBO_LEN_LSB);
      idx_r <= 5'h00;
      byte_mode_r <= 1'b0;
      mask_r <= 3'h0;
    end else begin
      if (wr && paddr == `TBO_OFF_DBC) begin
        base_r <= pwdata[`TBO_BASE_LSB +: 5];
        len_r <= pwdata[`TBO_LEN_LSB +: 5];
        idx_r <= 5'h00;
      end else if (done && is_win) begin
        idx_r <= wrap ? 5'h00 : 5'(({1'b0, idx_r} + idx_step));
      end
      if (wr && paddr == `TBO_OFF_BCFG) byte_mode_r <= pwdata[0];
      if (wr && paddr == `TBO_OFF_MASK) mask_r <= pwdata[2:0];
    end
  end

  // break/output control; lock field itself is writable only while unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_r <= 8'(`TBO_BOC_RST & 16'h00ff);
      lock_r <= 2'h0;
      idle_off_r <= 1'b0;
      run_off_r <= 1'b0;
      brk_en_r <= 1'b0;
      brk_pol_r <= 1'b0;
      aoe_r <= 1'b0;
    end else if (wr && paddr == `TBO_OFF_BOC) begin
      if (lock_r == 2'h0) begin
        dt_r <= pwdata[7:0];
        lock_r <= pwdata[`TBO_LOCK_LSB +: 2];
        brk_en_r <= pwdata[`TBO_BREAK_ENABLE_BIT];
        brk_pol_r <= pwdata[`TBO_BREAK_POLARITY_BIT];
        aoe_r <= pwdata[`TBO_AOE_BIT];
      end
      if (lock_r < 2'h2) begin
        idle_off_r <= pwdata[`TBO_IDLE_BIT];
        run_off_r <= pwdata[`TBO_RUN_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) brk_pol_eff_r <= 1'b0;
    else brk_pol_eff_r <= brk_pol_r;
  end

  tbo_sync #(.W(1)) u_brk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(break_input),
    .q(brk_pin_s)
  );
  // polarity applied behind the synchroniser for status and auto enable; the raw pin also feeds moe_rst_n below
  assign brk_act_s = brk_pin_s ~^ brk_pol_eff_r;

  // only when enabled, polarity applied
  // the pin reaches this reset unsynchronised on purpose: no clock is waited for
  assign moe_rst_n = presetn & ~(brk_en_r & (break_input ~^ brk_pol_eff_r));
  assign sw_moe_wr = wr && (paddr == `TBO_OFF_BOC);
  assign auto_set = aoe_r && upd_evt && !(brk_en_r && brk_act_s) && !moe_r;

  always_ff @(posedge pclk or negedge moe_rst_n) begin
    if (!moe_rst_n) moe_r <= 1'b0;
    else if (sw_moe_wr) moe_r <= pwdata[`TBO_MOE_BIT];
    else if (auto_set) moe_r <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) main_output_enable <= 1'b0;
    else main_output_enable <= moe_r;
  end

  // sticky status, cleared by reading; a new event wins over the clear
  assign brk_evt = brk_en_r && brk_act_s && !brk_act_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_act_d_r <= 1'b0;
      status_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      brk_act_d_r <= brk_act_s;
      status_r <= (status_r & ~((done && !pwrite && paddr == `TBO_OFF_STAT) ? prdata[2:0] : 3'h0))
                  | {(done && is_win && wrap), (auto_set && !sw_moe_wr), brk_evt};
      irq <= |(status_r & mask_r);
    end
  end

  tbo_out_stage #(.NCH(NCH)) u_out (
    .pclk(pclk),
    .presetn(presetn),
    .moe(moe_r),
    .idle_off(idle_off_r),
    .run_off(run_off_r),
    .dead_time(dt_r),
    .oc_ref(oc_ref),
    .ch_en(channel_output_enable),
    .comp_en(channel_comp_output_enable),
    .ch_pol(ch_pol),
    .comp_pol(comp_pol),
    .idle_lvl(idle_lvl),
    .idle_lvl_comp(idle_lvl_comp),
    .out_val(compare_output),
    .out_en(compare_output_en),
    .outc_val(compare_output_comp),
    .outc_en(compare_output_comp_en)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle_off;
    (!moe_r && !idle_off_r) ##1 (!moe_r && !idle_off_r) |->
      (compare_output_en == '0) && (compare_output_comp_en == '0);
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle off-state outputs driven");

  property p_idle_on;
    (!moe_r && idle_off_r) ##1 (!moe_r && idle_off_r) |->
      compare_output_en == $past(channel_output_enable | channel_comp_output_enable);
  endproperty
  a_idle_on: assert property (p_idle_on) else $error("idle outputs not driven");

  property p_run_off;
    (moe_r && !run_off_r) ##1 (moe_r && !run_off_r) |->
      (compare_output_en & ~$past(channel_output_enable)) == '0;
  endproperty
  a_run_off: assert property (p_run_off) else $error("disabled run channel driven");

  property p_brk_en;
    !brk_en_r && !$past(brk_en_r) |->
      !status_r[`TBO_ST_BREAK] || $past(status_r[`TBO_ST_BREAK]);
  endproperty
  a_brk_en: assert property (p_brk_en) else $error("break seen while disabled");

  property p_pol_delay;
    (brk_pol_r != $past(brk_pol_r)) |-> (brk_pol_eff_r != brk_pol_r) ##1 (brk_pol_eff_r == brk_pol_r);
  endproperty
  a_pol_delay: assert property (p_pol_delay) else $error("polarity not delayed one cycle");

  property p_brk_clear;
    (brk_en_r && brk_act_s && !$past(sw_moe_wr)) |-> !moe_r;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("main enable set during break");

  property p_moe_set;
    !moe_r ##1 moe_r |-> $past(sw_moe_wr) || $past(aoe_r && upd_evt);
  endproperty
  a_moe_set: assert property (p_moe_set) else $error("main enable set without cause");

  property p_run_on;
    moe_r ##1 moe_r |-> (compare_output_en & $past(channel_output_enable))
      == $past(channel_output_enable);
  endproperty
  a_run_on: assert property (p_run_on) else $error("enabled channel not driven");

  property p_lock;
    (lock_r != 2'h0) && sw_moe_wr |=> (brk_en_r == $past(brk_en_r))
      && (aoe_r == $past(aoe_r)) && (brk_pol_r == $past(brk_pol_r));
  endproperty
  a_lock: assert property (p_lock) else $error("locked bit changed");

  property p_win_strobe;
    (psel && !penable && is_win && state_r == TBO_ST_IDLE) |=> burst_req ##[1:2] pready;
  endproperty
  a_win_strobe: assert property (p_win_strobe) else $error("window access gave no strobe");

  property p_idx;
    (done && is_win && !byte_mode_r) |=> idx_r == ($past(idx_r) == $past(len_r) ? 5'h00
      : 5'($past(idx_r) + 5'h01));
  endproperty
  a_idx: assert property (p_idx) else $error("burst index did not advance");

  property p_addr;
    (burst_req && state_r == TBO_ST_HI) |->
      burst_addr == 8'(`TBO_CTRL1_ADDR + 8'(4 * (base_r + idx_r)));
  endproperty
  a_addr: assert property (p_addr) else $error("burst target address wrong");

  property p_rsvd;
    (state_r == TBO_ST_RESP && paddr == `TBO_OFF_DBC && !pwrite) |->
      prdata[31:13] == '0 && prdata[7:5] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");
endmodule // tbo_top

/* verification/tbo_dma_tgt.sv */
// timer register file answering burst accesses, standing in for the dma target side
`timescale 1ns/1ns
module tbo_dma_tgt (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic burst_req, // one-cycle target access
  input wire logic burst_we, // access is a write
  input wire logic [7:0] burst_addr, // byte address of target
  input wire logic [15:0] burst_wdata, // write data
  output logic [15:0] burst_rdata // read data, valid with burst_req
);
  logic [15:0] mem [0:63];
  logic [15:0] last_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (burst_req && burst_we) begin
      mem[burst_addr[7:2]] <= burst_wdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= 16'h0000;
    end else if (burst_req) begin
      last_r <= mem[burst_addr[7:2]];
    end
  end
  // released bus shows inverse, never the stale word
  assign burst_rdata = burst_req ? mem[burst_addr[7:2]] : ~last_r;
endmodule // tbo_dma_tgt

/* verification/tb_timer_break_output_dma_burst.sv */
// self-checking bench: apb register access, burst window, break and outputs
`timescale 1ns/1ns
`include "tbo_cfg.svh"
module tb_timer_break_output_dma_burst;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, break_input = 1'b0, upd_evt = 1'b0;
  logic [3:0] oc_ref = 4'h0, ch_en = 4'h0, comp_en = 4'h0;
  logic [3:0] ch_pol = 4'h0, comp_pol = 4'h0, idle_lvl = 4'h5, idle_lvl_comp = 4'ha;
  logic [3:0] co, co_en, coc, coc_en;
  logic moe, burst_req, burst_we, irq;
  logic [7:0] burst_addr;
  logic [15:0] burst_wdata, burst_rdata;
  logic [31:0] rd;
  logic err;
  int miscompares = 0, checks = 0, cyc = 0;

  always #20 pclk = ~pclk;

  tbo_top #(.NCH(4)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .break_input(break_input), .upd_evt(upd_evt), .oc_ref(oc_ref),
    .channel_output_enable(ch_en), .channel_comp_output_enable(comp_en), .ch_pol(ch_pol),
    .comp_pol(comp_pol), .idle_lvl(idle_lvl), .idle_lvl_comp(idle_lvl_comp),
    .compare_output(co), .compare_output_en(co_en), .compare_output_comp(coc),
    .compare_output_comp_en(coc_en), .main_output_enable(moe), .burst_req(burst_req),
    .burst_we(burst_we), .burst_addr(burst_addr), .burst_wdata(burst_wdata),
    .burst_rdata(burst_rdata), .irq(irq));

  tbo_dma_tgt tgt_u (.pclk(pclk), .presetn(presetn), .burst_req(burst_req),
    .burst_we(burst_we), .burst_addr(burst_addr), .burst_wdata(burst_wdata),
    .burst_rdata(burst_rdata));

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    idle(12);
    presetn <= 1'b1;
    apb(0, `TBO_OFF_DBC, 0); chk("dbc reset", rd, 32'h0);
    apb(0, `TBO_OFF_BOC, 0); chk("boc reset", rd, 32'h0);
    apb(1, `TBO_OFF_DBC, 32'hffff_ffff);
    apb(0, `TBO_OFF_DBC, 0); chk("dbc fields", rd, 32'h0000_1f1f);
    apb(0, 8'h7c, 0); chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // base 1, three transfers, then wrap back to the base
    apb(1, `TBO_OFF_DBC, 32'h0000_0201);
    for (int i = 0; i < 3; i++) begin
      apb(1, `TBO_OFF_WIN, 32'h1110 + i);
    end
    for (int i = 0; i < 3; i++) begin
      chk("burst target", {16'h0, tgt_u.mem[1 + i]}, 32'h1110 + i);
    end
    apb(1, `TBO_OFF_WIN, 32'h2222);
    chk("burst wrap", {16'h0, tgt_u.mem[1]}, 32'h2222);
    apb(0, `TBO_OFF_STAT, 0); chk("wrap status", rd, 32'h4);
    apb(0, `TBO_OFF_WIN, 0); chk("burst read", rd & 32'hffff, 32'h1111);
    // byte mode: upper byte first register, lower byte next
    apb(1, `TBO_OFF_BCFG, 32'h1);
    apb(1, `TBO_OFF_DBC, 32'h0000_0100);
    apb(1, `TBO_OFF_WIN, 32'h0000_abcd);
    chk("byte upper", {24'h0, tgt_u.mem[0][7:0]}, 32'hab);
    chk("byte lower", {24'h0, tgt_u.mem[1][7:0]}, 32'hcd);
    apb(0, `TBO_OFF_WIN, 0); chk("byte read", rd & 32'hffff, 32'habcd);
    apb(1, `TBO_OFF_BCFG, 32'h0);
    apb(0, `TBO_OFF_STAT, 0);
    // outputs in idle mode with off-state 0
    ch_en <= 4'hf;
    idle(4);
    chk("idle off0 en", {28'h0, co_en}, 32'h0);
    apb(1, `TBO_OFF_BOC, 32'h8000);
    idle(4);
    chk("moe", {31'h0, moe}, 32'h1);
    chk("run en", {28'h0, co_en}, 32'hf);
    chk("run comp en", {28'h0, coc_en}, 32'h0);
    ch_en <= 4'h0;
    idle(4);
    chk("run off0 en", {28'h0, co_en}, 32'h0);
    apb(1, `TBO_OFF_BOC, 32'h0400);
    ch_en <= 4'hf;
    comp_en <= 4'hf;
    idle(6);
    chk("idle off1 en", {28'h0, co_en & coc_en}, 32'hf);
    chk("idle lvl", {28'h0, co}, {28'h0, idle_lvl});
    chk("idle lvl comp", {28'h0, coc}, {28'h0, idle_lvl_comp});
    // dead time of four cycles: channel 0 inactive first, then idle level
    ch_en <= 4'h0;
    comp_en <= 4'h0;
    apb(1, `TBO_OFF_BOC, 32'h0404);
    ch_en <= 4'h1;
    idle(3);
    chk("dead inactive", {28'h0, co}, 32'h4);
    idle(6);
    chk("dead then idle", {28'h0, co}, 32'h5);
    // break disabled: pin has no effect
    apb(1, `TBO_OFF_BOC, 32'ha000);
    break_input <= 1'b1;
    idle(4);
    chk("break off", {31'h0, moe}, 32'h1);
    break_input <= 1'b0;
    apb(1, `TBO_OFF_MASK, 32'h3);
    apb(1, `TBO_OFF_BOC, 32'hb000);
    idle(4);
    chk("break armed", {31'h0, moe}, 32'h1);
    break_input <= 1'b1;
    idle(5);
    chk("break clears", {31'h0, moe}, 32'h0);
    chk("break irq", {31'h0, irq}, 32'h1);
    // auto enable blocked while break active
    apb(1, `TBO_OFF_BOC, 32'h7000);
    upd_evt <= 1'b1;
    @(posedge pclk);
    upd_evt <= 1'b0;
    idle(4);
    chk("auto blocked", {31'h0, moe}, 32'h0);
    break_input <= 1'b0;
    idle(4);
    apb(0, `TBO_OFF_STAT, 0); chk("break status", rd & 32'h1, 32'h1);
    idle(3);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1, `TBO_OFF_BOC, 32'h3000);
    upd_evt <= 1'b1;
    @(posedge pclk);
    upd_evt <= 1'b0;
    idle(4);
    chk("no auto", {31'h0, moe}, 32'h0);
    apb(1, `TBO_OFF_BOC, 32'h7000);
    upd_evt <= 1'b1;
    @(posedge pclk);
    upd_evt <= 1'b0;
    idle(4);
    chk("auto set", {31'h0, moe}, 32'h1);
    chk("auto irq", {31'h0, irq}, 32'h1);
    apb(0, `TBO_OFF_STAT, 0); chk("auto status", rd, 32'h2);
    // lock level 1 freezes break and auto bits
    apb(1, `TBO_OFF_BOC, 32'h0100);
    apb(1, `TBO_OFF_BOC, 32'h7100);
    apb(0, `TBO_OFF_BOC, 0); chk("locked bits", rd, 32'h0100);
    final_report();
  end
endmodule // tb_timer_break_output_dma_burst
